// file: src/stu_defines.svh
/*
 * Constants for the subtract and trap unit: operation codes, register
 * offsets, field positions, reset values and vector limits.
 * Assumes it is included by bare name from the evaluator and top design files; the package does not include it.
 */
`ifndef STU_DEFINES_SVH
`define STU_DEFINES_SVH

// ==========================================================
// Operation codes from the instruction pipeline
`define STU_OP_SUB 3'h0
`define STU_OP_SUBU 3'h1
`define STU_OP_TB0 3'h2
`define STU_OP_TB1 3'h3
`define STU_OP_TBND 3'h4
`define STU_OP_TCND 3'h5

// ==========================================================
// Register byte offsets on APB
`define STU_ADDR_CTRL 12'h000
`define STU_ADDR_VBR 12'h004
`define STU_ADDR_PSR 12'h008
`define STU_ADDR_STATUS 12'h00C
`define STU_ADDR_MASK 12'h010

// ==========================================================
// Fields and reset values
`define STU_CTRL_EN_BIT 0
`define STU_CTRL_RESET 1'h1
`define STU_PSR_CARRY_BIT 0
`define STU_VBR_RESET 20'h00000
`define STU_VBR_PAGE_LSB 12
`define STU_EVT_W 4
`define STU_EVT_OVF 0
`define STU_EVT_TRAP 1
`define STU_EVT_PRIV 2
`define STU_EVT_BOUNDS 3
`define STU_EVT_NONE 4'h0

// ==========================================================
// Register numbers and vectors
`define STU_REG_ZERO 5'h00
`define STU_HW_VEC_LAST 9'h07F
`define STU_BOUNDS_VEC 9'h005
`define STU_IMM_PAD 16'h0000
`define STU_VEC_PAD 3'h0

`endif

// file: src/stu_pkg.sv
/*
 * Types shared by the subtract and trap unit.
 * Assumes stu_defines.svh is on the include path.
 */
package stu_pkg;

	// ==========================================================
	// Sequencing states of the unit
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_DRAIN,
		ST_EXEC
	} stu_state_t;

	typedef logic [31:0] stu_word_t;

endpackage : stu_pkg

// file: src/stu_eval.sv
/*
 * Combinational evaluator: difference, carry, overflow, bit test,
 * sign/zero condition match and unsigned bounds compare.
 * Assumes operands already have register zero and immediates resolved.
 */
`include "stu_defines.svh"

module stu_eval
	import stu_pkg::*;
(
	// Operands
	input wire stu_word_t op_a,
	input wire stu_word_t op_b,
	// Carry control
	input wire logic carry_in_en,
	input wire logic carry_flag,
	// Trap fields
	input wire logic [4:0] bit_number,
	input wire logic [4:0] cond_match,
	// Results
	output stu_word_t diff,
	output logic carry_out,
	output logic overflow,
	output logic bit_value,
	output logic cond_hit,
	output logic above
);

	logic cin;
	logic [32:0] full_sum;
	logic [31:0] low_sum;
	logic sign_bit;
	logic zero_bit;

	// Carry flag replaces the constant one; a clear flag is a borrow
	assign cin = carry_in_en ? carry_flag : 1'b1;

	// Ones complement of the second operand over all 32 bits
	assign full_sum = {1'b0, op_a} + {1'b0, ~op_b} + {32'h0, cin};
	assign low_sum = {1'b0, op_a[30:0]} + {1'b0, ~op_b[30:0]} + {31'h0, cin};
	assign diff = full_sum[31:0];
	assign carry_out = full_sum[32];

	// Carry into the sign bit against carry out of it
	assign overflow = low_sum[31] ^ full_sum[32];

	// Selected bit of the first source
	assign bit_value = op_a[bit_number];

	// Sign and zero form a 2-bit index; the top field bit is never used
	assign sign_bit = op_a[31];
	assign zero_bit = ~|op_a[30:0];
	assign cond_hit = cond_match[{sign_bit, zero_bit}];

	// Unsigned out-of-bounds test
	assign above = op_a > op_b;

endmodule : stu_eval

// file: src/stu_top.sv
/*
 * Subtract and trap unit of the integer pipeline: signed and unsigned
 * subtract with borrow in and out, bit-test, bounds and condition traps,
 * vector forming, user-mode privilege check and pipeline drain.
 * Assumes a pipeline on the same clock that holds an operation until
 * op_ready_q, an exception sequencer taking one-cycle pulses, and an APB
 * master for the control registers.
 */
// The register addresses and the APB interface to the registers were chosen for this implementation.
`include "stu_defines.svh"

// Summary of operation
// - Difference is first operand plus inverted second plus one or carry.
// - Carry-out enable writes subtraction carry to status carry flag, else kept.
// - Signed subtract raises overflow when sign-bit carry in and out differ.
// - Immediate form zero-extends the 16-bit field as second operand.
// - Register zero reads zero; results aimed at it are dropped.
// - Bit-clear trap fires when the selected source bit is zero.
// - Bit-set trap fires when the selected source bit is one.
// - Vector is base upper twenty bits, nine-bit number, three zeros.
// - Bit-test and condition traps wait until the pipeline is drained.
// - User-mode trap to vectors 0 to 127 is a privilege violation.
// - Bounds trap when first source exceeds second or immediate, unsigned.
// - Bounds trap runs at once, with no pipeline drain.
// - Condition trap indexes match field with sign and low-bits-zero flag.
// - Field bits: 25 unused, 24 S&Z, 23 S&~Z, 22 ~S&Z, 21 neither.
// - Clear carry means pending borrow, set carry means no borrow.
module stu_top
	import stu_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Operation request from the pipeline
	input wire logic op_valid,
	input wire logic [2:0] op_code,
	input wire logic [4:0] src1_reg,
	input wire stu_word_t src1_val,
	input wire logic [4:0] src2_reg,
	input wire stu_word_t src2_val,
	input wire logic [4:0] dest_reg,
	input wire logic [15:0] immediate_operand_field,
	input wire logic use_imm,
	input wire logic carry_in_en,
	input wire logic carry_out_en,
	input wire logic [4:0] tested_bit_number,
	input wire logic [8:0] trap_vector_number,
	input wire logic [4:0] condition_match_field,
	input wire logic user_mode,
	input wire logic pipe_empty,
	output logic op_ready_q,
	output logic sync_stall_q,
	// Result write-back
	output stu_word_t result_q,
	output logic result_we_q,
	output logic [4:0] result_reg_q,
	output logic psr_carry_q,
	// Exception sequencer
	output logic overflow_exc_q,
	output logic priv_exc_q,
	output logic bounds_exc_q,
	output logic trap_req_q,
	output stu_word_t trap_vector_q,
	output logic suppress_q,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire stu_word_t pwdata,
	output stu_word_t prdata_q,
	output logic pready_q,
	output logic pslverr_q,
	// Interrupt
	output logic irq_q
);

	// ==========================================================
	// Declarations
	stu_state_t state_q;
	stu_state_t state_d;
	logic accept;
	logic needs_sync;
	logic [2:0] op_code_q;
	stu_word_t a_q;
	stu_word_t b_q;
	logic carry_in_en_q;
	logic carry_out_en_q;
	logic [4:0] dest_q;
	logic [4:0] bit_q;
	logic [8:0] vec_q;
	logic [4:0] match_q;
	logic user_q;
	stu_word_t op_a;
	stu_word_t op_b;
	stu_word_t diff;
	logic carry_out;
	logic overflow;
	logic bit_value;
	logic cond_hit;
	logic above;
	logic [`STU_EVT_W-1:0] evt_d;
	logic wr_d;
	logic carry_upd;
	stu_word_t vec_d;
	logic ctrl_en_q;
	logic [19:0] vbr_q;
	logic [`STU_EVT_W-1:0] status_q;
	logic [`STU_EVT_W-1:0] mask_q;
	logic apb_setup;
	logic apb_wr;
	logic rd_hit;
	stu_word_t rd_data;
	logic [`STU_EVT_W-1:0] status_clr;

	// ==========================================================
	// Operand resolution
	// Register zero is forced here so stale file contents never leak in
	assign op_a = (src1_reg == `STU_REG_ZERO) ? 32'h0 : src1_val;
	always_comb begin
		if (use_imm) begin
			op_b = {`STU_IMM_PAD, immediate_operand_field};
		end else if (src2_reg == `STU_REG_ZERO) begin
			op_b = 32'h0;
		end else begin
			op_b = src2_val;
		end
	end

	// ==========================================================
	// Sequencing
	// Operations are only taken while idle, and only if the unit was enabled one cycle earlier
	assign accept = op_valid & op_ready_q;
	// The bounds trap is left out on purpose: it never drains
	assign needs_sync = (op_code == `STU_OP_TB0) ||
		(op_code == `STU_OP_TB1) || (op_code == `STU_OP_TCND);

	// Next state
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE: begin
				if (accept) begin
					state_d = needs_sync ? ST_DRAIN : ST_EXEC;
				end
			end
			ST_DRAIN: begin
				// Hold until scoreboard and data pipeline report empty
				if (pipe_empty) begin
					state_d = ST_EXEC;
				end
			end
			ST_EXEC: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// State register and handshake
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= ST_IDLE;
			op_ready_q <= 1'b0;
			sync_stall_q <= 1'b0;
		end else begin
			state_q <= state_d;
			op_ready_q <= (state_d == ST_IDLE) & ctrl_en_q;
			sync_stall_q <= (state_d == ST_DRAIN);
		end
	end

	// Operation capture at acceptance
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			op_code_q <= `STU_OP_SUB;
			a_q <= 32'h0;
			b_q <= 32'h0;
			carry_in_en_q <= 1'b0;
			carry_out_en_q <= 1'b0;
			dest_q <= `STU_REG_ZERO;
			bit_q <= 5'h00;
			vec_q <= 9'h000;
			match_q <= 5'h00;
			user_q <= 1'b0;
		end else if (accept) begin
			op_code_q <= op_code;
			a_q <= op_a;
			b_q <= op_b;
			carry_in_en_q <= carry_in_en;
			carry_out_en_q <= carry_out_en;
			dest_q <= dest_reg;
			bit_q <= tested_bit_number;
			vec_q <= trap_vector_number;
			match_q <= condition_match_field;
			user_q <= user_mode;
		end
	end

	// ==========================================================
	// Evaluation
	stu_eval u_eval (
		.op_a(a_q),
		.op_b(b_q),
		.carry_in_en(carry_in_en_q),
		.carry_flag(psr_carry_q),
		.bit_number(bit_q),
		.cond_match(match_q),
		.diff(diff),
		.carry_out(carry_out),
		.overflow(overflow),
		.bit_value(bit_value),
		.cond_hit(cond_hit),
		.above(above)
	);

	// Outcome of the executing operation
	// An overflowing signed subtract is precise: no write, carry kept
	always_comb begin
		evt_d = `STU_EVT_NONE;
		wr_d = 1'b0;
		carry_upd = 1'b0;
		vec_d = trap_vector_q;
		if (state_q == ST_EXEC) begin
			unique case (op_code_q)
				`STU_OP_SUB, `STU_OP_SUBU: begin
					if (op_code_q == `STU_OP_SUB && overflow) begin
						evt_d[`STU_EVT_OVF] = 1'b1;
					end else begin
						wr_d = (dest_q != `STU_REG_ZERO);
						carry_upd = carry_out_en_q;
					end
				end
				`STU_OP_TB0, `STU_OP_TB1, `STU_OP_TCND: begin
					if (user_q && vec_q <= `STU_HW_VEC_LAST) begin
						evt_d[`STU_EVT_PRIV] = 1'b1;
					end else if ((op_code_q == `STU_OP_TB0 && !bit_value) ||
						(op_code_q == `STU_OP_TB1 && bit_value) ||
						(op_code_q == `STU_OP_TCND && cond_hit)) begin
						evt_d[`STU_EVT_TRAP] = 1'b1;
						vec_d = {vbr_q, vec_q, `STU_VEC_PAD};
					end
				end
				`STU_OP_TBND: begin
					if (above) begin
						evt_d[`STU_EVT_BOUNDS] = 1'b1;
						vec_d = {vbr_q, `STU_BOUNDS_VEC, `STU_VEC_PAD};
					end
				end
				default: begin
					// Undefined codes retire with no effect
				end
			endcase
		end
	end

	// Write-back and exception pulses
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			result_q <= 32'h0;
			result_we_q <= 1'b0;
			result_reg_q <= `STU_REG_ZERO;
			overflow_exc_q <= 1'b0;
			priv_exc_q <= 1'b0;
			bounds_exc_q <= 1'b0;
			trap_req_q <= 1'b0;
			suppress_q <= 1'b0;
			trap_vector_q <= 32'h0;
		end else begin
			result_we_q <= wr_d;
			result_reg_q <= dest_q;
			if (wr_d) begin
				result_q <= diff;
			end
			overflow_exc_q <= evt_d[`STU_EVT_OVF];
			priv_exc_q <= evt_d[`STU_EVT_PRIV];
			bounds_exc_q <= evt_d[`STU_EVT_BOUNDS];
			trap_req_q <= evt_d[`STU_EVT_TRAP];
			// Any exception squashes the instructions behind it
			suppress_q <= |evt_d;
			trap_vector_q <= vec_d;
		end
	end

	// ==========================================================
	// Status carry flag
	// Hardware update wins over a software write in the same cycle
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			psr_carry_q <= 1'b0;
		end else if (carry_upd) begin
			psr_carry_q <= carry_out;
		end else if (apb_wr && paddr == `STU_ADDR_PSR) begin
			psr_carry_q <= pwdata[`STU_PSR_CARRY_BIT];
		end
	end

	// ==========================================================
	// APB slave
	// Zero wait states: pready rises for the first access cycle
	assign apb_setup = psel & ~penable;
	assign apb_wr = psel & penable & pready_q & pwrite;

	// Read decode; unmapped or misaligned offsets answer with an error
	always_comb begin
		rd_hit = 1'b1;
		rd_data = 32'h0;
		case (paddr)
			`STU_ADDR_CTRL: rd_data[`STU_CTRL_EN_BIT] = ctrl_en_q;
			`STU_ADDR_VBR: rd_data = {vbr_q, 12'h000};
			`STU_ADDR_PSR: rd_data[`STU_PSR_CARRY_BIT] = psr_carry_q;
			`STU_ADDR_STATUS: rd_data[`STU_EVT_W-1:0] = status_q;
			`STU_ADDR_MASK: rd_data[`STU_EVT_W-1:0] = mask_q;
			default: rd_hit = 1'b0;
		endcase
	end

	// Bus answer registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0;
		end else begin
			pready_q <= apb_setup;
			if (apb_setup) begin
				pslverr_q <= ~rd_hit;
				prdata_q <= pwrite ? 32'h0 : rd_data;
			end
		end
	end

	// Control and vector base registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_en_q <= `STU_CTRL_RESET;
			vbr_q <= `STU_VBR_RESET;
			mask_q <= `STU_EVT_NONE;
		end else if (apb_wr) begin
			if (paddr == `STU_ADDR_CTRL) begin
				ctrl_en_q <= pwdata[`STU_CTRL_EN_BIT];
			end
			if (paddr == `STU_ADDR_VBR) begin
				vbr_q <= pwdata[31:`STU_VBR_PAGE_LSB];
			end
			if (paddr == `STU_ADDR_MASK) begin
				mask_q <= pwdata[`STU_EVT_W-1:0];
			end
		end
	end

	// ==========================================================
	// Interrupt status
	// Write one to clear; a new event in the same cycle stays set
	assign status_clr = (apb_wr && paddr == `STU_ADDR_STATUS) ?
		pwdata[`STU_EVT_W-1:0] : `STU_EVT_NONE;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			status_q <= `STU_EVT_NONE;
			irq_q <= 1'b0;
		end else begin
			status_q <= (status_q & ~status_clr) | evt_d;
			irq_q <= |(((status_q & ~status_clr) | evt_d) & mask_q);
		end
	end

endmodule : stu_top

// file: tb/stu_top_sva.sv
/*
 * Port checker for the subtract and trap unit.
 * Assumes it is bound onto stu_top: one clock, reset_n async low.
 */
`include "stu_defines.svh"

module stu_top_sva
	import stu_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Operation request
	input wire logic op_valid,
	input wire logic [2:0] op_code,
	input wire logic [4:0] src1_reg,
	input wire stu_word_t src1_val,
	input wire logic [4:0] src2_reg,
	input wire stu_word_t src2_val,
	input wire logic [4:0] dest_reg,
	input wire logic [15:0] immediate_operand_field,
	input wire logic use_imm,
	input wire logic carry_in_en,
	input wire logic carry_out_en,
	input wire logic pipe_empty,
	input wire logic op_ready_q,
	input wire logic sync_stall_q,
	// Results and exceptions
	input wire stu_word_t result_q,
	input wire logic result_we_q,
	input wire logic psr_carry_q,
	input wire logic priv_exc_q,
	input wire logic bounds_exc_q,
	input wire logic trap_req_q,
	input wire stu_word_t trap_vector_q,
	input wire logic suppress_q
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	// ==========================================================
	// Helpers
	logic take;
	logic is_sub;
	stu_word_t opnd_b;
	assign take = op_valid && op_ready_q;
	assign is_sub = op_code == `STU_OP_SUB || op_code == `STU_OP_SUBU;
	// Immediate replaces the second register when selected
	assign opnd_b = use_imm ? {`STU_IMM_PAD, immediate_operand_field} : src2_val;

	// ==========================================================
	// Properties
	property p_diff;
		take && op_code == `STU_OP_SUBU && !carry_in_en &&
		src1_reg != `STU_REG_ZERO && dest_reg != `STU_REG_ZERO &&
		(use_imm || src2_reg != `STU_REG_ZERO) |-> ##2 result_we_q &&
		result_q == $past(src1_val, 2) - $past(opnd_b, 2);
	endproperty
	a_diff: assert property (p_diff) else $error("bad difference");
	property p_zero;
		take && is_sub && dest_reg == `STU_REG_ZERO |-> ##2 !result_we_q;
	endproperty
	a_zero: assert property (p_zero) else $error("r0 written");
	property p_keep;
		take && is_sub && !carry_out_en |->
		##2 psr_carry_q == $past(psr_carry_q, 2);
	endproperty
	a_keep: assert property (p_keep) else $error("carry changed");
	property p_sync;
		take && (op_code == `STU_OP_TB0 || op_code == `STU_OP_TB1 ||
		op_code == `STU_OP_TCND) |=> sync_stall_q;
	endproperty
	a_sync: assert property (p_sync) else $error("no drain");
	property p_drain;
		sync_stall_q && !pipe_empty |=> sync_stall_q;
	endproperty
	a_drain: assert property (p_drain) else $error("left drain early");
	property p_nosync;
		take && op_code == `STU_OP_TBND |=> !sync_stall_q ##1 op_ready_q;
	endproperty
	a_nosync: assert property (p_nosync) else $error("bounds waited");
	property p_priv;
		priv_exc_q |-> suppress_q && !trap_req_q;
	endproperty
	a_priv: assert property (p_priv) else $error("bad privilege trap");
	property p_trap;
		trap_req_q |-> suppress_q && trap_vector_q[2:0] == `STU_VEC_PAD;
	endproperty
	a_trap: assert property (p_trap) else $error("bad trap");
	property p_bvec;
		bounds_exc_q |->
		trap_vector_q[11:0] == {`STU_BOUNDS_VEC, `STU_VEC_PAD};
	endproperty
	a_bvec: assert property (p_bvec) else $error("bad bounds vector");
	c_trap: cover property (trap_req_q);
	c_priv: cover property (priv_exc_q);
	c_bnd: cover property (bounds_exc_q);
endmodule : stu_top_sva

// file: tb/stu_pipe_model.sv
/*
 * Pipeline model: reports empty only after drain_len stalled cycles.
 * Assumes sync_stall_q from the unit on the same clock.
 */
module stu_pipe_model (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Drain handshake
	input wire logic sync_stall_q,
	input wire logic [3:0] drain_len,
	output logic pipe_empty
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt_q;

	// Busy outside a stall, so a unit that skips draining is caught
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) cnt_q <= 4'h0;
		else if (!sync_stall_q) cnt_q <= 4'h0;
		else if (cnt_q != 4'hF) cnt_q <= cnt_q + 4'h1;
	end
	assign pipe_empty = sync_stall_q && cnt_q >= drain_len;
endmodule : stu_pipe_model

// file: tb/test_subtract_and_trap_unit.sv
/*
 * Bench for stu_top: APB and operation tasks, directed sequences.
 * Assumes stu_pipe_model as far side and stu_top_sva bound in.
 */
`include "stu_defines.svh"

module test_subtract_and_trap_unit
	import stu_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, reset_n, op_valid, use_imm, carry_in_en, carry_out_en;
	logic user_mode, psel, penable, pwrite, zr, pipe_empty, op_ready_q;
	logic sync_stall_q, result_we_q, psr_carry_q, overflow_exc_q, err;
	logic priv_exc_q, bounds_exc_q, trap_req_q, suppress_q, pready_q;
	logic pslverr_q, irq_q;
	logic [2:0] op_code;
	logic [4:0] src1_reg, src2_reg, dest_reg, result_reg_q;
	logic [4:0] tested_bit_number, condition_match_field;
	logic [15:0] immediate_operand_field;
	logic [8:0] trap_vector_number;
	logic [11:0] paddr;
	logic [3:0] drain_len;
	stu_word_t src1_val, src2_val, pwdata, prdata_q, result_q;
	stu_word_t trap_vector_q, rd;
	int miscompares, checks_done, n;
	localparam stu_word_t V = 32'hABCDE000;
	stu_word_t opv [4] = '{32'h0, 32'h5, 32'h80000005, 32'h80000000};
	logic [4:0] cm [7] = '{5'h02, 5'h0D, 5'h01, 5'h0C, 5'h03, 5'h0E, 5'h10};
	// Expected trap per encoding, bit j set when opv[j] meets the condition
	logic [3:0] hit [7] = '{4'h1, 4'hE, 4'h2, 4'hC, 4'h3, 4'hD, 4'h0};

	stu_top DUT (.clk, .reset_n, .op_valid, .op_code, .src1_reg, .src1_val,
		.src2_reg, .src2_val, .dest_reg, .immediate_operand_field, .use_imm,
		.carry_in_en, .carry_out_en, .tested_bit_number, .trap_vector_number,
		.condition_match_field, .user_mode, .pipe_empty, .op_ready_q,
		.sync_stall_q, .result_q, .result_we_q, .result_reg_q, .psr_carry_q,
		.overflow_exc_q, .priv_exc_q, .bounds_exc_q, .trap_req_q,
		.trap_vector_q, .suppress_q, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata_q, .pready_q, .pslverr_q, .irq_q);
	stu_pipe_model u_pipe (.clk, .reset_n, .sync_stall_q, .drain_len,
		.pipe_empty);

	// ==========================================================
	// Shared tasks
	task results;
		if (miscompares == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : results
	task chk(input stu_word_t got, input stu_word_t exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task tmo;
		if (n >= 40) begin
			miscompares++;
			$display("mismatch at %0t: no answer", $time);
			results();
		end
	endtask : tmo
	// Holds the request until pready is seen high at a rising edge
	task apb(input logic w, input logic [11:0] a, input stu_word_t wd);
		@(posedge clk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin @(posedge clk); n++; end while (pready_q !== 1'b1 && n < 40);
		tmo();
		rd = prdata_q;
		err = pslverr_q;
		psel <= 1'b0; penable <= 1'b0;
	endtask : apb
	task rdc(input logic [11:0] a, input stu_word_t ex, input logic er);
		apb(1'b0, a, 32'h0);
		chk(rd, ex);
		chk({31'h0, err}, {31'h0, er});
	endtask : rdc
	// The interrupt follows a mask write one edge late
	task irqc(input logic x);
		@(posedge clk);
		@(negedge clk);
		chk({31'h0, irq_q}, {31'h0, x});
	endtask : irqc
	// One operation; outputs are judged when the unit goes idle again
	task op(input logic [2:0] c, input stu_word_t a, input stu_word_t b,
		input logic [4:0] m, input logic [5:0] xev, input stu_word_t xv);
		@(posedge clk);
		op_valid <= 1'b1; op_code <= c; src1_val <= a; src2_val <= b;
		src1_reg <= zr ? 5'h00 : 5'h01; src2_reg <= zr ? 5'h00 : 5'h02;
		dest_reg <= zr ? 5'h00 : 5'h03;
		tested_bit_number <= m; condition_match_field <= m;
		n = 0;
		do begin @(negedge clk); n++; end while (op_ready_q !== 1'b1 && n < 40);
		tmo();
		@(posedge clk);
		op_valid <= 1'b0;
		n = 0;
		do begin @(negedge clk); n++; end while (op_ready_q !== 1'b1 && n < 40);
		tmo();
		chk({26'h0, result_we_q, overflow_exc_q, priv_exc_q, bounds_exc_q,
			trap_req_q, suppress_q}, {26'h0, xev});
		if (xev[5]) begin
			chk(result_q, xv);
			chk({27'h0, result_reg_q}, 32'h3);
		end else if (xev[2] | xev[1]) begin
			chk(trap_vector_q, xv);
		end
		@(posedge clk);
	endtask : op

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// ==========================================================
	// Main sequence
	initial begin
		{reset_n, op_valid, use_imm, carry_in_en, carry_out_en} = '0;
		{user_mode, psel, penable, pwrite, zr, op_code, paddr} = '0;
		{src1_reg, src2_reg, dest_reg, tested_bit_number} = '0;
		{condition_match_field, immediate_operand_field} = '0;
		{trap_vector_number, src1_val, src2_val, pwdata} = '0;
		drain_len = 4'h3;
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		rdc(`STU_ADDR_CTRL, 32'h1, 1'b0);
		rdc(`STU_ADDR_VBR, 32'h0, 1'b0);
		rdc(`STU_ADDR_STATUS, 32'h0, 1'b0);
		rdc(`STU_ADDR_MASK, 32'h0, 1'b0);
		rdc(12'h020, 32'h0, 1'b1);
		apb(1'b1, `STU_ADDR_VBR, 32'hABCDE123);
		rdc(`STU_ADDR_VBR, V, 1'b0);
		apb(1'b1, `STU_ADDR_MASK, 32'hF);
		carry_out_en <= 1'b1;
		op(`STU_OP_SUBU, 32'h5, 32'h3, 5'h0, 6'h20, 32'h2);
		chk({31'h0, psr_carry_q}, 32'h1);
		carry_in_en <= 1'b1;
		op(`STU_OP_SUBU, 32'h0, 32'h1, 5'h0, 6'h20, 32'hFFFFFFFF);
		chk({31'h0, psr_carry_q}, 32'h0);
		carry_out_en <= 1'b0;
		op(`STU_OP_SUBU, 32'h5, 32'h1, 5'h0, 6'h20, 32'h3);
		carry_in_en <= 1'b0; use_imm <= 1'b1;
		immediate_operand_field <= 16'h8000;
		op(`STU_OP_SUBU, 32'h10000, 32'hFFFFFFFF, 5'h0, 6'h20, 32'h8000);
		use_imm <= 1'b0;
		op(`STU_OP_SUB, 32'h80000000, 32'h1, 5'h0, 6'h11, 32'h0);
		op(`STU_OP_SUBU, 32'h80000000, 32'h1, 5'h0, 6'h20, 32'h7FFFFFFF);
		zr <= 1'b1; carry_out_en <= 1'b1;
		op(`STU_OP_SUB, 32'h7, 32'h9, 5'h0, 6'h00, 32'h0);
		chk({31'h0, psr_carry_q}, 32'h1);
		rdc(`STU_ADDR_PSR, 32'h1, 1'b0);
		apb(1'b1, `STU_ADDR_PSR, 32'h0);
		rdc(`STU_ADDR_PSR, 32'h0, 1'b0);
		// A disabled unit refuses work; ready falls one edge after the write
		apb(1'b1, `STU_ADDR_CTRL, 32'h0);
		@(posedge clk);
		@(negedge clk);
		chk({31'h0, op_ready_q}, 32'h0);
		apb(1'b1, `STU_ADDR_CTRL, 32'h1);
		zr <= 1'b0; carry_out_en <= 1'b0; trap_vector_number <= 9'h080;
		op(`STU_OP_TB0, 32'hFFFFFFEF, 32'h0, 5'h04, 6'h03, V | 32'h400);
		op(`STU_OP_TB0, 32'h10, 32'h0, 5'h04, 6'h00, 32'h0);
		op(`STU_OP_TB1, 32'h80000000, 32'h0, 5'h1F, 6'h03, V | 32'h400);
		op(`STU_OP_TB1, 32'h7FFFFFFF, 32'h0, 5'h1F, 6'h00, 32'h0);
		user_mode <= 1'b1; trap_vector_number <= 9'h07F;
		op(`STU_OP_TB1, 32'h0, 32'h0, 5'h0, 6'h09, 32'h0);
		trap_vector_number <= 9'h080;
		op(`STU_OP_TB1, 32'h1, 32'h0, 5'h0, 6'h03, V | 32'h400);
		user_mode <= 1'b0; drain_len <= 4'hF;
		op(`STU_OP_TBND, 32'hA, 32'h9, 5'h0, 6'h05, V | 32'h28);
		op(`STU_OP_TBND, 32'h9, 32'h9, 5'h0, 6'h00, 32'h0);
		use_imm <= 1'b1; immediate_operand_field <= 16'h0009;
		op(`STU_OP_TBND, 32'h10000, 32'hFFFFFFFF, 5'h0, 6'h05, V | 32'h28);
		use_imm <= 1'b0; drain_len <= 4'h1;
		// Each encoding against zero, positive, negative and most negative
		for (int i = 0; i < 7; i++) begin
			for (int j = 0; j < 4; j++) begin
				op(`STU_OP_TCND, opv[j], 32'h0, cm[i],
					hit[i][j] ? 6'h03 : 6'h00,
					V | 32'h400);
			end
		end
		rdc(`STU_ADDR_STATUS, 32'hF, 1'b0);
		irqc(1'b1);
		apb(1'b1, `STU_ADDR_MASK, 32'h0);
		irqc(1'b0);
		apb(1'b1, `STU_ADDR_MASK, 32'hF);
		irqc(1'b1);
		apb(1'b1, `STU_ADDR_STATUS, 32'hF);
		rdc(`STU_ADDR_STATUS, 32'h0, 1'b0);
		irqc(1'b0);
		results();
	end
endmodule : test_subtract_and_trap_unit

bind stu_top stu_top_sva u_sva (.clk, .reset_n, .op_valid, .op_code,
	.src1_reg, .src1_val, .src2_reg, .src2_val, .dest_reg,
	.immediate_operand_field, .use_imm, .carry_in_en, .carry_out_en,
	.pipe_empty, .op_ready_q, .sync_stall_q, .result_q, .result_we_q,
	.psr_carry_q, .priv_exc_q, .bounds_exc_q, .trap_req_q, .trap_vector_q,
	.suppress_q);
